/* File: verilog/vpic_pkg.sv */
// Constants for the vectored priority interrupt controller.
// Assumes a single 100 MHz clock and a 32-bit register bus.
package vpic_pkg;

   // Source counts and field widths
   localparam int N_EXT = 4;
   localparam int N_INT = 8;
   localparam int N_STD = 12;
   localparam int N_SRC = 13;
   localparam int FAST_IDX = 12;
   localparam int PRIO_W = 3;
   localparam int IDX_W = 4;
   localparam int ADDR_W = 8;

   // Register byte offsets; configuration words start at CFG_BASE
   localparam logic [7:0] OFF_CFG_BASE = 8'h00;
   localparam logic [7:0] OFF_ENABLE = 8'h40;
   localparam logic [7:0] OFF_PENDING = 8'h44;
   localparam logic [7:0] OFF_VECTOR = 8'h48;
   localparam logic [7:0] OFF_VBASE = 8'h4C;
   localparam logic [7:0] OFF_CLKCTL = 8'h50;
   localparam logic [7:0] OFF_RAW = 8'h54;

   // Field positions inside a configuration word and the clock control word
   localparam int CFG_PRIO_LSB = 0;
   localparam int CFG_MODE_LSB = 4;
   localparam int CLK_GATE_BIT = 0;

   // Values after reset, and the shift that scales the vector index
   localparam logic [2:0] RST_PRIO = 3'h0;
   localparam logic [1:0] RST_MODE = 2'h0;
   localparam logic [12:0] RST_ENABLE = 13'h0000;
   localparam logic [31:0] RST_VBASE = 32'h0000_0000;
   localparam int VEC_SHIFT = 2;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Detection options; on-chip sources only use the upper bit
   typedef enum logic [1:0] {
      VPIC_LVL_HIGH = 2'b00,
      VPIC_LVL_LOW = 2'b01,
      VPIC_EDGE_RISE = 2'b10,
      VPIC_EDGE_FALL = 2'b11
   } vpic_sense_t;

endpackage

/* File: verilog/vpic_arb_if.sv */
// Bundle between the controller core and its priority encoder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
interface vpic_arb_if #(
   parameter int N = 12,
   parameter int PW = 3,
   parameter int IW = 4
);
   logic [N-1:0] req;
   logic [PW-1:0] prio [N];
   logic valid;
   logic [IW-1:0] idx;
   logic [PW-1:0] level;

   modport arb (input req, input prio, output valid, output idx,
      output level);
   modport ctl (output req, output prio, input valid, input idx,
      input level);
endinterface

/* File: verilog/vpic_arb.sv */
// Eight-level priority encoder choosing one standard source.
// Assumes requests already masked; purely combinational.
`timescale 1ns/10ps
module vpic_arb #(
   parameter int N = 12,
   parameter int PW = 3,
   parameter int IW = 4
) (
   // Request side
   vpic_arb_if.arb arb
);

   always_comb begin
      arb.valid = 1'b0;
      arb.idx = '0;
      arb.level = '0;
      for (int i = 0; i < N; i++) begin
         // Strict compare keeps the lowest number on a tie
         if (arb.req[i] && (!arb.valid || arb.prio[i] > arb.level)) begin
            arb.valid = 1'b1;
            arb.idx = IW'(i);
            arb.level = arb.prio[i];
         end
      end
   end

endmodule // vpic_arb

/* File: verilog/vpic_ctrl.sv */
// Vectored priority interrupt controller with an AXI4-Lite slave.
// Assumes pins are asynchronous; on-chip requests share i_clock.
`timescale 1ns/10ps
module vpic_ctrl (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // AXI4-Lite write address and data
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // External request pins
   input wire logic i_ext_fast_request_pin,
   input wire logic [3:0] i_ext_request_pin,
   // On-chip peripheral requests
   input wire logic i_port_ctrl_a_irq,
   input wire logic i_port_ctrl_b_irq,
   input wire logic [5:0] i_timer_channel_irq,
   // Core side
   output logic o_core_fast_request_line_n,
   output logic o_core_standard_request_line_n,
   output logic [31:0] o_vector,
   output logic o_core_clock_run
);

   localparam int NS = vpic_pkg::N_SRC;
   localparam int NX = vpic_pkg::N_EXT + 1;

   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction

   function automatic logic is_cfg(input logic [7:0] a);
      return a < (vpic_pkg::OFF_CFG_BASE + 8'(NS * 4));
   endfunction

   function automatic logic sense(input logic [1:0] mode,
      input logic now, input logic prev);
      logic hit;
      case (vpic_pkg::vpic_sense_t'(mode))
         vpic_pkg::VPIC_LVL_HIGH: hit = now;
         vpic_pkg::VPIC_LVL_LOW: hit = ~now;
         vpic_pkg::VPIC_EDGE_RISE: hit = now & ~prev;
         vpic_pkg::VPIC_EDGE_FALL: hit = ~now & prev;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Pin synchronisers, then one stage kept for edge detection
   logic [NX-1:0] meta_ff, sync_ff, ext_prev_ff;
   logic [vpic_pkg::N_INT-1:0] int_raw, int_prev_ff;
   logic [NS-1:0] in_now, in_prev;

   // Configuration and state
   logic [2:0] prio_ff [NS];
   logic [2:0] nxt_prio [NS];
   logic [1:0] mode_ff [NS];
   logic [1:0] nxt_mode [NS];
   logic [NS-1:0] enable_ff, nxt_enable;
   logic [NS-1:0] edge_lat_ff, nxt_edge_lat;
   logic [31:0] vbase_ff, nxt_vbase;
   logic [31:0] vector_ff, nxt_vector;
   logic gated_ff, nxt_gated;
   logic fast_n_ff, nxt_fast_n;
   logic std_n_ff, nxt_std_n;
   logic [NS-1:0] pending, hit, clr;

   // Bus state
   logic aw_got_ff, nxt_aw_got;
   logic w_got_ff, nxt_w_got;
   logic [7:0] awaddr_ff, nxt_awaddr;
   logic [31:0] wdata_ff, nxt_wdata;
   logic [3:0] wstrb_ff, nxt_wstrb;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;
   logic do_wr;
   logic [31:0] wmask, wbits;

   vpic_arb_if #(.N(vpic_pkg::N_STD), .PW(vpic_pkg::PRIO_W),
      .IW(vpic_pkg::IDX_W)) arb_bus ();

   vpic_arb #(.N(vpic_pkg::N_STD), .PW(vpic_pkg::PRIO_W),
      .IW(vpic_pkg::IDX_W)) u_arb (
      .arb (arb_bus.arb)
   );

   // Index order: pins 0-3, port ctrl a, port ctrl b, timers, fast pin
   assign int_raw = {i_timer_channel_irq, i_port_ctrl_b_irq,
      i_port_ctrl_a_irq};
   assign in_now = {sync_ff[vpic_pkg::N_EXT], int_raw,
      sync_ff[vpic_pkg::N_EXT-1:0]};
   assign in_prev = {ext_prev_ff[vpic_pkg::N_EXT], int_prev_ff,
      ext_prev_ff[vpic_pkg::N_EXT-1:0]};

   // Write channel acceptance; write lands once both halves are held
   assign o_s_axi_awready = ~aw_got_ff & ~bvalid_ff;
   assign o_s_axi_wready = ~w_got_ff & ~bvalid_ff;
   assign o_s_axi_arready = ~rvalid_ff;
   assign do_wr = aw_got_ff & w_got_ff & ~bvalid_ff;
   assign wmask = strb_mask(wstrb_ff);
   assign wbits = wdata_ff & wmask;

   always_comb begin
      nxt_aw_got = aw_got_ff;
      nxt_w_got = w_got_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb = wstrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      if (i_s_axi_awvalid && o_s_axi_awready) begin
         nxt_aw_got = 1'b1;
         nxt_awaddr = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
         nxt_w_got = 1'b1;
         nxt_wdata = i_s_axi_wdata;
         nxt_wstrb = i_s_axi_wstrb;
      end
      if (do_wr) begin
         nxt_aw_got = 1'b0;
         nxt_w_got = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = vpic_pkg::RESP_SLVERR;
         if (is_cfg(awaddr_ff) || awaddr_ff == vpic_pkg::OFF_ENABLE ||
            awaddr_ff == vpic_pkg::OFF_PENDING ||
            awaddr_ff == vpic_pkg::OFF_VBASE ||
            awaddr_ff == vpic_pkg::OFF_CLKCTL) begin
            nxt_bresp = vpic_pkg::RESP_OKAY;
         end
      end else if (bvalid_ff && i_s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
   end

   // Register writes and detection
   always_comb begin
      int ci;
      ci = int'(awaddr_ff[7:2]);
      nxt_enable = enable_ff;
      nxt_vbase = vbase_ff;
      clr = '0;
      for (int i = 0; i < NS; i++) begin
         nxt_prio[i] = prio_ff[i];
         nxt_mode[i] = mode_ff[i];
      end
      if (do_wr) begin
         if (is_cfg(awaddr_ff)) begin
            if (wstrb_ff[0]) begin
               nxt_prio[ci] = wdata_ff[vpic_pkg::CFG_PRIO_LSB +: 3];
               nxt_mode[ci] = wdata_ff[vpic_pkg::CFG_MODE_LSB +: 2];
               // On-chip sources have no polarity choice
               if (ci >= vpic_pkg::N_EXT && ci < vpic_pkg::FAST_IDX) begin
                  nxt_mode[ci][0] = 1'b0;
               end
            end
         end else if (awaddr_ff == vpic_pkg::OFF_ENABLE) begin
            nxt_enable = (enable_ff & ~wmask[NS-1:0]) | wbits[NS-1:0];
         end else if (awaddr_ff == vpic_pkg::OFF_PENDING) begin
            clr = wbits[NS-1:0];
         end else if (awaddr_ff == vpic_pkg::OFF_VBASE) begin
            nxt_vbase = (vbase_ff & ~wmask) | wbits;
         end
      end
      for (int i = 0; i < NS; i++) begin
         hit[i] = sense(mode_ff[i], in_now[i], in_prev[i]);
         // A new edge in the clearing cycle is kept
         nxt_edge_lat[i] = mode_ff[i][1] &
            ((edge_lat_ff[i] & ~clr[i]) | hit[i]);
         pending[i] = mode_ff[i][1] ? edge_lat_ff[i] : hit[i];
      end
   end

   // Arbitration and core lines
   always_comb begin
      arb_bus.req = pending[vpic_pkg::N_STD-1:0] &
         enable_ff[vpic_pkg::N_STD-1:0];
      for (int i = 0; i < vpic_pkg::N_STD; i++) begin
         arb_bus.prio[i] = prio_ff[i];
      end
      nxt_std_n = ~arb_bus.valid;
      nxt_fast_n = ~(pending[vpic_pkg::FAST_IDX] &
         enable_ff[vpic_pkg::FAST_IDX]);
      // With nothing pending the vector points at a spurious slot
      nxt_vector = vbase_ff + (arb_bus.valid ?
         {28'h000_0000, arb_bus.idx} << vpic_pkg::VEC_SHIFT :
         32'(vpic_pkg::N_STD) << vpic_pkg::VEC_SHIFT);
      nxt_gated = gated_ff;
      if (do_wr && awaddr_ff == vpic_pkg::OFF_CLKCTL &&
         wbits[vpic_pkg::CLK_GATE_BIT]) begin
         nxt_gated = 1'b1;
      end
      // A request in the gating cycle still keeps the clock running
      if (|(pending & enable_ff)) begin
         nxt_gated = 1'b0;
      end
   end

   // Read path
   always_comb begin
      logic [7:0] a;
      a = i_s_axi_araddr;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (i_s_axi_arvalid && o_s_axi_arready) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = vpic_pkg::RESP_OKAY;
         nxt_rdata = '0;
         if (is_cfg(a)) begin
            nxt_rdata[vpic_pkg::CFG_PRIO_LSB +: 3] = prio_ff[int'(a[7:2])];
            nxt_rdata[vpic_pkg::CFG_MODE_LSB +: 2] = mode_ff[int'(a[7:2])];
         end else if (a == vpic_pkg::OFF_ENABLE) begin
            nxt_rdata[NS-1:0] = enable_ff;
         end else if (a == vpic_pkg::OFF_PENDING) begin
            nxt_rdata[NS-1:0] = pending;
         end else if (a == vpic_pkg::OFF_VECTOR) begin
            nxt_rdata = vector_ff;
         end else if (a == vpic_pkg::OFF_VBASE) begin
            nxt_rdata = vbase_ff;
         end else if (a == vpic_pkg::OFF_CLKCTL) begin
            nxt_rdata[vpic_pkg::CLK_GATE_BIT] = gated_ff;
         end else if (a == vpic_pkg::OFF_RAW) begin
            nxt_rdata[NS-1:0] = in_now;
         end else begin
            nxt_rresp = vpic_pkg::RESP_SLVERR;
         end
      end else if (rvalid_ff && i_s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      // Synchronisers carry no reset so the pin level flows through
      meta_ff <= {i_ext_fast_request_pin, i_ext_request_pin};
      sync_ff <= meta_ff;
      ext_prev_ff <= sync_ff;
      int_prev_ff <= int_raw;
      if (i_srst) begin
         for (int i = 0; i < NS; i++) begin
            prio_ff[i] <= vpic_pkg::RST_PRIO;
            mode_ff[i] <= vpic_pkg::RST_MODE;
         end
         enable_ff <= vpic_pkg::RST_ENABLE;
         edge_lat_ff <= '0;
         vbase_ff <= vpic_pkg::RST_VBASE;
         vector_ff <= vpic_pkg::RST_VBASE;
         gated_ff <= 1'b0;
         fast_n_ff <= 1'b1;
         std_n_ff <= 1'b1;
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff <= vpic_pkg::RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= vpic_pkg::RESP_OKAY;
      end else begin
         prio_ff <= nxt_prio;
         mode_ff <= nxt_mode;
         enable_ff <= nxt_enable;
         edge_lat_ff <= nxt_edge_lat;
         vbase_ff <= nxt_vbase;
         vector_ff <= nxt_vector;
         gated_ff <= nxt_gated;
         fast_n_ff <= nxt_fast_n;
         std_n_ff <= nxt_std_n;
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         awaddr_ff <= nxt_awaddr;
         wdata_ff <= nxt_wdata;
         wstrb_ff <= nxt_wstrb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   assign o_s_axi_bvalid = bvalid_ff;
   assign o_s_axi_bresp = bresp_ff;
   assign o_s_axi_rvalid = rvalid_ff;
   assign o_s_axi_rdata = rdata_ff;
   assign o_s_axi_rresp = rresp_ff;
   assign o_core_fast_request_line_n = fast_n_ff;
   assign o_core_standard_request_line_n = std_n_ff;
   assign o_vector = vector_ff;
   assign o_core_clock_run = ~gated_ff;

endmodule // vpic_ctrl

/* File: test/vpic_ctrl_assertions.sv */
// Checker on the interrupt controller top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module vpic_ctrl_checker (
   // Clock, reset and bus
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic [1:0] o_s_axi_bresp,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic o_s_axi_rvalid,
   // Fast pin and core side
   input wire logic i_ext_fast_request_pin,
   input wire logic o_core_fast_request_line_n,
   input wire logic o_core_standard_request_line_n,
   input wire logic [31:0] o_vector,
   input wire logic o_core_clock_run
);
   logic pin_ff;
   logic hit;
   logic [3:0] qf_ff;
   logic [3:0] nxt_qf;
   assign hit = (i_s_axi_awvalid & o_s_axi_awready) |
      (i_s_axi_wvalid & o_s_axi_wready);
   // Quiet cycles since the fast pin or a bus write could move the line
   always_comb begin
      nxt_qf = qf_ff + {3'h0, qf_ff != 4'hF};
      if (i_srst | hit | (i_ext_fast_request_pin != pin_ff)) nxt_qf = 4'h0;
   end
   always_ff @(posedge i_clock) begin
      qf_ff <= nxt_qf;
      pin_ff <= i_ext_fast_request_pin;
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_srst);
   property p_rst_vals;
      disable iff (1'b0) i_srst ##1 i_srst |-> o_core_fast_request_line_n
         && o_core_standard_request_line_n && o_vector == 32'h0000_0000
         && o_core_clock_run;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("outputs off reset values");
   property p_fast_move;
      $changed(o_core_fast_request_line_n) |-> qf_ff < 4'h6;
   endproperty
   a_fast_move: assert property (p_fast_move)
      else $error("fast line moved with no fast pin cause");
   property p_wake;
      !(o_core_fast_request_line_n && o_core_standard_request_line_n) |->
         ##[0:2] o_core_clock_run;
   endproperty
   a_wake: assert property (p_wake)
      else $error("request did not restart core clock");
   property p_b_hold;
      o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid &&
         $stable(o_s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_aw_block;
      o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready;
   endproperty
   a_aw_block: assert property (p_aw_block)
      else $error("write taken while response pending");
   property p_ar_block;
      o_s_axi_rvalid |-> !o_s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block)
      else $error("read taken while data pending");
   property p_r_lat;
      i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat)
      else $error("read data late");
   property p_w_lat;
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
         o_s_axi_wready |-> !o_s_axi_bvalid [*2] ##1 o_s_axi_bvalid;
   endproperty
   a_w_lat: assert property (p_w_lat)
      else $error("write response timing wrong");
   c_fast: cover property ($fell(o_core_fast_request_line_n));
   c_std: cover property ($fell(o_core_standard_request_line_n));
   c_gate: cover property ($fell(o_core_clock_run));
endmodule // vpic_ctrl_checker
bind vpic_ctrl vpic_ctrl_checker i_vpic_ctrl_checker (.*);

/* File: test/vpic_core_model.sv */
// Core-side model counting entries on each request line.
// Assumes active-low lines registered in the same clock.
`timescale 1ns/10ps
module vpic_core_model (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Request lines
   input wire logic i_fast_n,
   input wire logic i_std_n,
   // Entry counts
   output logic [7:0] o_n_fast,
   output logic [7:0] o_n_std
);
   logic fast_ff;
   logic std_ff;
   // The core enters once per falling edge, not per low cycle
   always_ff @(posedge i_clock) begin
      fast_ff <= i_fast_n;
      std_ff <= i_std_n;
      if (i_srst) begin
         o_n_fast <= 8'h00;
         o_n_std <= 8'h00;
      end else begin
         o_n_fast <= o_n_fast + {7'h00, fast_ff & ~i_fast_n};
         o_n_std <= o_n_std + {7'h00, std_ff & ~i_std_n};
      end
   end
endmodule // vpic_core_model

/* File: test/vpic_ctrl_tb.sv */
// Self-checking bench for the interrupt controller.
// Assumes the core model and the bound checker are compiled with it.
`timescale 1ns/10ps
module vpic_ctrl_tb;
   logic i_clock, i_srst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
   logic i_s_axi_arvalid, i_s_axi_rready, i_ext_fast_request_pin;
   logic i_port_ctrl_a_irq, i_port_ctrl_b_irq, o_core_clock_run;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
   logic o_s_axi_arready, o_s_axi_rvalid;
   logic o_core_fast_request_line_n, o_core_standard_request_line_n;
   logic [7:0] i_s_axi_awaddr, i_s_axi_araddr, n_fast, n_std;
   logic [31:0] i_s_axi_wdata, o_s_axi_rdata, o_vector;
   logic [3:0] i_s_axi_wstrb, i_ext_request_pin;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
   logic [5:0] i_timer_channel_irq;
   int n_fail = 0;
   int n_checks = 0;
   vpic_ctrl i_vpic_ctrl (
      .i_clock(i_clock), .i_srst(i_srst),
      .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
      .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
      .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
      .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp),
      .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
      .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
      .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
      .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
      .i_s_axi_rready(i_s_axi_rready),
      .i_ext_fast_request_pin(i_ext_fast_request_pin),
      .i_ext_request_pin(i_ext_request_pin),
      .i_port_ctrl_a_irq(i_port_ctrl_a_irq),
      .i_port_ctrl_b_irq(i_port_ctrl_b_irq),
      .i_timer_channel_irq(i_timer_channel_irq),
      .o_core_fast_request_line_n(o_core_fast_request_line_n),
      .o_core_standard_request_line_n(o_core_standard_request_line_n),
      .o_vector(o_vector), .o_core_clock_run(o_core_clock_run));
   vpic_core_model i_vpic_core_model (.i_clock(i_clock), .i_srst(i_srst),
      .i_fast_n(o_core_fast_request_line_n),
      .i_std_n(o_core_standard_request_line_n),
      .o_n_fast(n_fast), .o_n_std(n_std));
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   task automatic lines(input logic f, input logic s);
      chk("fast line", 32'(f), 32'(o_core_fast_request_line_n));
      chk("std line", 32'(s), 32'(o_core_standard_request_line_n));
   endtask
   task automatic vchk(input logic [31:0] e);
      cyc(6);
      chk("vector", e, o_vector);
   endtask
   // One bus transfer; for a read d is the expected data
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [1:0] er = vpic_pkg::RESP_OKAY);
      int k;
      @(posedge i_clock);
      i_s_axi_awaddr <= a;
      i_s_axi_araddr <= a;
      i_s_axi_wdata <= d;
      {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= {3{w}};
      {i_s_axi_arvalid, i_s_axi_rready} <= {2{~w}};
      for (k = 0; k < 40; k++) begin
         @(posedge i_clock);
         if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
         if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
         if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
         if (w ? o_s_axi_bvalid : o_s_axi_rvalid) break;
      end
      {i_s_axi_bready, i_s_axi_rready} <= 2'h0;
      chk("timeout", 32'h0000_0000, 32'(k == 40));
      chk("resp", 32'(er), 32'(w ? o_s_axi_bresp : o_s_axi_rresp));
      if (!w) chk("rdata", d, o_s_axi_rdata);
      if (k == 40) summarize();
   endtask
   initial begin
      logic [1:0] md;
      {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_s_axi_awvalid,
         i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready,
         i_ext_fast_request_pin, i_ext_request_pin, i_port_ctrl_a_irq,
         i_port_ctrl_b_irq, i_timer_channel_irq} = '0;
      i_s_axi_wstrb = 4'hF;
      i_srst = 1'b1;
      cyc(5);
      i_srst <= 1'b0;
      cyc(1);
      lines(1'b1, 1'b1);
      chk("vector", 32'h0000_0000, o_vector);
      for (int i = 0; i < 13; i++) xfer(0, 8'(4 * i), 32'h0000_0000);
      xfer(0, 8'h34, 32'h0000_0000, vpic_pkg::RESP_SLVERR);
      xfer(0, 8'h4C, 32'h0000_0000);
      xfer(0, 8'hFC, 32'h0000_0000, vpic_pkg::RESP_SLVERR);
      xfer(1, 8'hFC, 32'hFFFF_FFFF, vpic_pkg::RESP_SLVERR);
      $display("reset and map done");
      xfer(1, 8'h40, 32'h0000_1FFF);
      xfer(1, 8'h4C, 32'h0000_1000);
      i_port_ctrl_a_irq <= 1'b1;
      vchk(32'h0000_1010);
      lines(1'b1, 1'b0);
      i_ext_fast_request_pin <= 1'b1;
      vchk(32'h0000_1010);
      lines(1'b0, 1'b0);
      $display("fast line done");
      xfer(1, 8'h10, 32'h0000_0002);
      xfer(1, 8'h18, 32'h0000_0005);
      xfer(1, 8'h1C, 32'h0000_0005);
      i_ext_fast_request_pin <= 1'b0;
      i_timer_channel_irq <= 6'h02;
      vchk(32'h0000_101C);
      i_timer_channel_irq <= 6'h03;
      vchk(32'h0000_1018);
      xfer(1, 8'h40, 32'h0000_1FBF);
      vchk(32'h0000_101C);
      xfer(1, 8'h40, 32'h0000_1F3F);
      i_port_ctrl_b_irq <= 1'b1;
      vchk(32'h0000_1010);
      i_port_ctrl_a_irq <= 1'b0;
      vchk(32'h0000_1014);
      {i_port_ctrl_b_irq, i_timer_channel_irq} <= 7'h00;
      vchk(32'h0000_1030);
      lines(1'b1, 1'b1);
      $display("priority done");
      // Every pin detection option, idle level first, then active
      xfer(1, 8'h40, 32'h0000_0001);
      for (int m = 0; m < 4; m++) begin
         md = 2'(m);
         i_ext_request_pin <= {3'h0, md[0]};
         cyc(6);
         xfer(1, 8'h00, 32'(md) << 4);
         xfer(1, 8'h44, 32'h0000_0001);
         cyc(2);
         lines(1'b1, 1'b1);
         i_ext_request_pin <= {3'h0, ~md[0]};
         cyc(6);
         lines(1'b1, 1'b0);
         i_ext_request_pin <= {3'h0, md[0]};
         cyc(6);
         lines(1'b1, ~md[1]);
         xfer(1, 8'h44, 32'h0000_0001);
         cyc(2);
         lines(1'b1, 1'b1);
      end
      $display("pin modes done");
      xfer(1, 8'h40, 32'h0000_0040);
      // Polarity bit is asked for but an on-chip source drops it
      xfer(1, 8'h18, 32'h0000_0030);
      xfer(0, 8'h18, 32'h0000_0020);
      i_timer_channel_irq <= 6'h01;
      cyc(1);
      i_timer_channel_irq <= 6'h00;
      vchk(32'h0000_1018);
      lines(1'b1, 1'b0);
      xfer(0, 8'h44, 32'h0000_0040);
      xfer(0, 8'h48, 32'h0000_1018);
      xfer(0, 8'h54, 32'h0000_0001);
      xfer(0, 8'h40, 32'h0000_0040);
      xfer(1, 8'h44, 32'h0000_0040);
      cyc(2);
      lines(1'b1, 1'b1);
      $display("edge latch done");
      xfer(1, 8'h50, 32'h0000_0001);
      cyc(2);
      chk("clock run", 32'h0000_0000, 32'(o_core_clock_run));
      xfer(0, 8'h50, 32'h0000_0001);
      xfer(1, 8'h40, 32'h0000_0010);
      i_port_ctrl_a_irq <= 1'b1;
      cyc(6);
      chk("clock run", 32'h0000_0001, 32'(o_core_clock_run));
      chk("fast entries", 32'h0000_0001, 32'(n_fast));
      // Ten separate assertions of the standard line so far
      chk("std entries", 32'h0000_000A, 32'(n_std));
      i_port_ctrl_a_irq <= 1'b0;
      cyc(4);
      xfer(1, 8'h50, 32'h0000_0001);
      i_srst <= 1'b1;
      cyc(5);
      i_srst <= 1'b0;
      cyc(1);
      chk("clock run", 32'h0000_0001, 32'(o_core_clock_run));
      $display("wake done");
      summarize();
   end
endmodule // vpic_ctrl_tb
